// File: verilog/ars_pkg.sv
// constants, state and register types of the automatic restart sequencer
package ars_pkg;

	// ************************************************************
	// clock and time base
	// ************************************************************
	localparam int CLK_HZ = 50_000_000;
	localparam int MS_PER_S = 1000;
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;

	// ************************************************************
	// timing figures
	// ************************************************************
	localparam int SUCCESS_TIME_S = 1;
	localparam logic [15:0] SUCCESS_MS = 16'(SUCCESS_TIME_S * MS_PER_S);

	// ************************************************************
	// register byte offsets
	// ************************************************************
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_LIMIT = 8'h04;
	localparam logic [7:0] OFS_WAIT = 8'h08;
	localparam logic [7:0] OFS_RSTTIME = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_LIMIT = 8'h03;
	localparam logic [15:0] RST_WAIT_MS = 16'h03e8;
	localparam logic [15:0] RST_RSTTIME_MS = 16'h0000;

	// ************************************************************
	// status field positions
	// ************************************************************
	localparam int STS_CNT_LSB = 0;
	localparam int STS_EXH = 8;
	localparam int STS_FAILED = 9;
	localparam int STS_INVALID = 10;
	localparam int STS_SON = 11;
	localparam int STS_STATE_LSB = 12;

	// ************************************************************
	// restart mode codes
	// ************************************************************
	localparam logic [7:0] MODE_OFF = 8'h00;
	localparam logic [7:0] MODE_ACK_ONLY = 8'h01;
	localparam logic [7:0] MODE_PWR = 8'h04;
	localparam logic [7:0] MODE_FLT = 8'h06;
	localparam logic [7:0] MODE_PWR_MAN = 8'h0e;
	localparam logic [7:0] MODE_FLT_MAN = 8'h10;
	localparam logic [7:0] MODE_ALL = 8'h1a;

	// ************************************************************
	// sequencer states and state record
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ACKWAIT,
		ST_DELAY,
		ST_SWON,
		ST_VERIFY,
		ST_RUNOK,
		ST_FAILED
	} ars_state_e;

	typedef struct packed {
		ars_state_e st;
		logic [7:0] mode;
		logic [7:0] limit;
		logic [15:0] wait_ms;
		logic [15:0] rst_ms;
		logic [7:0] cnt;
		logic exhausted;
		logic failed;
		logic pwr_evt;
		logic fault_q;
		logic ack;
		logic son;
		logic wait_go;
		logic ok_go;
		logic rst_go;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ars_regs_s;

endpackage

// File: verilog/ars_ms_timer.sv
// millisecond down timer with its own prescaler
`timescale 1ns/1ps
module ars_ms_timer #(
	parameter int CYC_PER_MS = ars_pkg::CYC_PER_MS,
	parameter int MSW = 16
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic start,
	input wire logic [MSW-1:0] load_ms,
	// result
	output logic done
);

	localparam int PW = $clog2(CYC_PER_MS + 1);
	localparam logic [PW-1:0] PRE_LAST = PW'(CYC_PER_MS - 1);

	typedef struct packed {
		logic [PW-1:0] pre;
		logic [MSW-1:0] ms;
		logic running;
		logic done;
	} ars_tmr_s;

	ars_tmr_s r;
	ars_tmr_s next_r;

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_r = r;
		if (start) begin
			next_r.pre = '0;
			next_r.ms = load_ms;
			next_r.running = (load_ms != '0);
			next_r.done = (load_ms == '0);
		end else if (r.running) begin
			if (r.pre == PRE_LAST) begin
				next_r.pre = '0;
				next_r.ms = r.ms - 1'b1;
				if (r.ms == MSW'(1)) begin
					next_r.running = 1'b0;
					next_r.done = 1'b1;
				end
			end else begin
				next_r.pre = r.pre + 1'b1;
			end
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign done = r.done;

endmodule

// File: verilog/ars_sequencer.sv
// automatic restart sequencer with apb register file
// Functional notes
// - restart mode resets to disabled; nothing is acknowledged or switched on.
// - seven restart modes: off, ack only, power, fault, manual variants, all.
// - start attempt limit resets to three.
// - attempt limit acts only in modes 4, 6, 14, 16, 26.
// - each acknowledgement in those modes decrements the start attempt counter by one; at zero it sets exhausted instead.
// - limit n allows n+1 attempts; then restart failed fault is raised.
// - counter reloads when reset time expires after a successful start.
// - after failure, ramp stop plus acknowledge clears fault and reloads counter.
// - a write changing limit or mode reloads the counter.
// - wait time before an attempt resets to 1.0 s.
// - automatic switch-on after a fault is delayed by the wait time in modes 4, 6, 26; not in 14, 16.
// - auto ack always in 1, 26; with run in 4, 6; never 14, 16.
// - no switch-on in mode 1; others switch on only with run command.
// - attempt succeeds when no fault within one second after magnetizing.
`timescale 1ns/1ps
module ars_sequencer #(
	parameter int CYC_PER_MS = ars_pkg::CYC_PER_MS
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// drive control inputs
	input wire logic run_command,
	input wire logic ramp_stop_command,
	input wire logic fault_active,
	input wire logic power_fail,
	input wire logic manual_ack,
	input wire logic start_done,
	// drive control outputs
	output logic fault_ack,
	output logic switch_on_request,
	output logic restart_failed_fault
);

	ars_pkg::ars_regs_s r;
	ars_pkg::ars_regs_s next_r;
	logic wait_done;
	logic ok_done;
	logic rst_done;
	logic [15:0] wait_load;

	// ************************************************************
	// mode decoding
	// ************************************************************
	function automatic logic mode_valid(input logic [7:0] m);
		mode_valid = (m == ars_pkg::MODE_OFF) || (m == ars_pkg::MODE_ACK_ONLY)
			|| (m == ars_pkg::MODE_PWR) || (m == ars_pkg::MODE_FLT)
			|| (m == ars_pkg::MODE_PWR_MAN) || (m == ars_pkg::MODE_FLT_MAN)
			|| (m == ars_pkg::MODE_ALL);
	endfunction

	function automatic logic mode_active(input logic [7:0] m);
		mode_active = mode_valid(m) && (m != ars_pkg::MODE_OFF);
	endfunction

	function automatic logic uses_limit(input logic [7:0] m);
		uses_limit = (m == ars_pkg::MODE_PWR) || (m == ars_pkg::MODE_FLT)
			|| (m == ars_pkg::MODE_PWR_MAN) || (m == ars_pkg::MODE_FLT_MAN)
			|| (m == ars_pkg::MODE_ALL);
	endfunction

	function automatic logic uses_wait(input logic [7:0] m);
		uses_wait = (m == ars_pkg::MODE_PWR) || (m == ars_pkg::MODE_FLT)
			|| (m == ars_pkg::MODE_ALL);
	endfunction

	function automatic logic auto_acks(input logic [7:0] m, input logic run);
		if ((m == ars_pkg::MODE_ACK_ONLY) || (m == ars_pkg::MODE_ALL)) begin
			auto_acks = 1'b1;
		end else if ((m == ars_pkg::MODE_PWR) || (m == ars_pkg::MODE_FLT)) begin
			auto_acks = run;
		end else begin
			auto_acks = 1'b0;
		end
	endfunction

	function automatic logic restarts(input logic [7:0] m, input logic pwr);
		if ((m == ars_pkg::MODE_PWR) || (m == ars_pkg::MODE_PWR_MAN)) begin
			restarts = pwr;
		end else if ((m == ars_pkg::MODE_FLT) || (m == ars_pkg::MODE_FLT_MAN)
			|| (m == ars_pkg::MODE_ALL)) begin
			restarts = 1'b1;
		end else begin
			restarts = 1'b0;
		end
	endfunction

	// ************************************************************
	// timers
	// ************************************************************
	assign wait_load = uses_wait(r.mode) ? r.wait_ms : 16'h0000;

	ars_ms_timer #(.CYC_PER_MS(CYC_PER_MS), .MSW(16)) u_wait_tmr (
		.pclk(pclk),
		.presetn(presetn),
		.start(r.wait_go),
		.load_ms(wait_load),
		.done(wait_done)
	);

	ars_ms_timer #(.CYC_PER_MS(CYC_PER_MS), .MSW(16)) u_ok_tmr (
		.pclk(pclk),
		.presetn(presetn),
		.start(r.ok_go),
		.load_ms(ars_pkg::SUCCESS_MS),
		.done(ok_done)
	);

	ars_ms_timer #(.CYC_PER_MS(CYC_PER_MS), .MSW(16)) u_rst_tmr (
		.pclk(pclk),
		.presetn(presetn),
		.start(r.rst_go),
		.load_ms(r.rst_ms),
		.done(rst_done)
	);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		logic evt;
		logic acc;
		logic wr;
		logic reload;
		logic ack_ok;
		logic [31:0] rd;
		logic rd_err;
		evt = 1'b0;
		acc = 1'b0;
		wr = 1'b0;
		reload = 1'b0;
		ack_ok = 1'b0;
		rd = 32'h0000_0000;
		rd_err = 1'b0;
		next_r = r;
		next_r.ack = 1'b0;
		next_r.wait_go = 1'b0;
		next_r.ok_go = 1'b0;
		next_r.rst_go = 1'b0;
		next_r.fault_q = fault_active;
		evt = (fault_active && !r.fault_q) || power_fail;

		// apb access, one wait state
		acc = psel && penable;
		wr = acc && pwrite && r.pready;
		next_r.pready = acc && !r.pready;
		if (paddr == ars_pkg::OFS_MODE) begin
			rd = {24'h000000, r.mode};
		end else if (paddr == ars_pkg::OFS_LIMIT) begin
			rd = {24'h000000, r.limit};
		end else if (paddr == ars_pkg::OFS_WAIT) begin
			rd = {16'h0000, r.wait_ms};
		end else if (paddr == ars_pkg::OFS_RSTTIME) begin
			rd = {16'h0000, r.rst_ms};
		end else if (paddr == ars_pkg::OFS_STATUS) begin
			rd[ars_pkg::STS_CNT_LSB +: 8] = r.cnt;
			rd[ars_pkg::STS_EXH] = r.exhausted;
			rd[ars_pkg::STS_FAILED] = r.failed;
			rd[ars_pkg::STS_INVALID] = !mode_valid(r.mode);
			rd[ars_pkg::STS_SON] = r.son;
			rd[ars_pkg::STS_STATE_LSB +: 3] = r.st;
		end else begin
			rd_err = 1'b1;
		end
		if (acc && !r.pready) begin
			next_r.prdata = pwrite ? 32'h0000_0000 : rd;
			next_r.pslverr = rd_err;
		end else if (!acc) begin
			next_r.prdata = 32'h0000_0000;
			next_r.pslverr = 1'b0;
		end

		// sequencer
		case (r.st)
			ars_pkg::ST_IDLE: begin
				if (evt && mode_active(r.mode)) begin
					next_r.pwr_evt = power_fail;
					next_r.st = ars_pkg::ST_ACKWAIT;
				end
			end
			ars_pkg::ST_RUNOK: begin
				if (evt) begin
					next_r.pwr_evt = power_fail;
					next_r.st = ars_pkg::ST_ACKWAIT;
				end else if (rst_done && !r.rst_go) begin
					reload = 1'b1;
					next_r.st = ars_pkg::ST_IDLE;
				end
			end
			ars_pkg::ST_ACKWAIT: begin
				ack_ok = auto_acks(r.mode, run_command) || manual_ack;
				if (ack_ok) begin
					next_r.ack = 1'b1;
					if (uses_limit(r.mode)) begin
						if (r.cnt == 8'h00) begin
							next_r.exhausted = 1'b1;
						end else begin
							next_r.cnt = r.cnt - 8'h01;
						end
					end
					if (restarts(r.mode, r.pwr_evt)) begin
						next_r.st = ars_pkg::ST_DELAY;
						next_r.wait_go = 1'b1;
					end else begin
						next_r.st = ars_pkg::ST_IDLE;
					end
				end
			end
			ars_pkg::ST_DELAY, ars_pkg::ST_SWON, ars_pkg::ST_VERIFY: begin
				if (evt) begin
					next_r.son = 1'b0;
					next_r.pwr_evt = power_fail;
					if (uses_limit(r.mode) && r.exhausted) begin
						next_r.st = ars_pkg::ST_FAILED;
						next_r.failed = 1'b1;
					end else begin
						next_r.st = ars_pkg::ST_ACKWAIT;
					end
				end else if (r.st == ars_pkg::ST_DELAY) begin
					if (wait_done && !r.wait_go && run_command) begin
						next_r.st = ars_pkg::ST_SWON;
						next_r.son = 1'b1;
					end
				end else if (!run_command) begin
					next_r.son = 1'b0;
					next_r.st = ars_pkg::ST_IDLE;
				end else if (r.st == ars_pkg::ST_SWON) begin
					if (start_done) begin
						next_r.st = ars_pkg::ST_VERIFY;
						next_r.ok_go = 1'b1;
					end
				end else if (ok_done && !r.ok_go) begin
					next_r.son = 1'b0;
					next_r.st = ars_pkg::ST_RUNOK;
					next_r.rst_go = 1'b1;
				end
			end
			ars_pkg::ST_FAILED: begin
				if (ramp_stop_command && manual_ack) begin
					next_r.failed = 1'b0;
					next_r.ack = 1'b1;
					reload = 1'b1;
					next_r.st = ars_pkg::ST_IDLE;
				end
			end
			default: begin
				next_r.st = ars_pkg::ST_IDLE;
			end
		endcase

		// register writes
		if (wr) begin
			if (paddr == ars_pkg::OFS_MODE) begin
				next_r.mode = pwdata[7:0];
				if (pwdata[7:0] != r.mode) begin
					reload = 1'b1;
					if (r.st != ars_pkg::ST_FAILED) begin
						next_r.st = ars_pkg::ST_IDLE;
						next_r.son = 1'b0;
					end
				end
			end else if (paddr == ars_pkg::OFS_LIMIT) begin
				next_r.limit = pwdata[7:0];
				if (pwdata[7:0] != r.limit) begin
					reload = 1'b1;
				end
			end else if (paddr == ars_pkg::OFS_WAIT) begin
				next_r.wait_ms = pwdata[15:0];
			end else if (paddr == ars_pkg::OFS_RSTTIME) begin
				next_r.rst_ms = pwdata[15:0];
			end
		end

		if (reload) begin
			next_r.cnt = next_r.limit;
			next_r.exhausted = 1'b0;
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.st <= ars_pkg::ST_IDLE;
			r.mode <= ars_pkg::RST_MODE;
			r.limit <= ars_pkg::RST_LIMIT;
			r.cnt <= ars_pkg::RST_LIMIT;
			r.wait_ms <= ars_pkg::RST_WAIT_MS;
			r.rst_ms <= ars_pkg::RST_RSTTIME_MS;
		end else begin
			r <= next_r;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign fault_ack = r.ack;
	assign switch_on_request = r.son;
	assign restart_failed_fault = r.failed;

endmodule

// File: test/ars_properties.sv
// assertion checker of the restart sequencer ports
`timescale 1ns/1ps
module ars_properties (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// drive control
	input wire logic run_command,
	input wire logic ramp_stop_command,
	input wire logic manual_ack,
	input wire logic fault_ack,
	input wire logic switch_on_request,
	input wire logic restart_failed_fault
);
	// ************************************************************
	// mode shadow
	// ************************************************************
	logic [7:0] mode_sh;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_sh <= 8'h00;
		end else if (pready && pwrite && paddr == 8'h00) begin
			mode_sh <= pwdata[7:0];
		end
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && !pready;
	endsequence
	sequence s_clear;
		restart_failed_fault && ramp_stop_command && manual_ack;
	endsequence
	// ************************************************************
	// properties
	// ************************************************************
	a_pready_wait: assert property (s_setup ##1 s_access |=> pready)
		else $error("pready late");
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready too long");
	a_off_quiet: assert property (mode_sh == 8'h00 &&
		$past(mode_sh) == 8'h00 && !restart_failed_fault &&
		!$past(restart_failed_fault)
		|-> !fault_ack && !switch_on_request) else $error("off mode acted");
	a_ack_no_son: assert property (mode_sh == 8'h01 &&
		$past(mode_sh) == 8'h01 |-> !switch_on_request)
		else $error("switch on in ack mode");
	a_son_run: assert property (switch_on_request |->
		$past(run_command)) else $error("switch on without run");
	a_man_ack: assert property ((mode_sh == 8'h0e ||
		mode_sh == 8'h10) && fault_ack |-> $past(manual_ack))
		else $error("auto ack in manual mode");
	a_ack_pulse: assert property (fault_ack |=> !fault_ack)
		else $error("ack too long");
	a_fail_hold: assert property (restart_failed_fault &&
		!(ramp_stop_command && manual_ack) |=> restart_failed_fault)
		else $error("failed fault lost");
	a_fail_clear: assert property (s_clear |=>
		!restart_failed_fault && fault_ack) else $error("no clear");
	a_fail_stop: assert property (restart_failed_fault |->
		!switch_on_request) else $error("switch on while failed");
endmodule
bind ars_sequencer ars_properties u_props (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.run_command, .ramp_stop_command, .manual_ack, .fault_ack,
	.switch_on_request, .restart_failed_fault
);

// File: test/ars_drive_model.sv
// behavioural drive control facing the sequencer
`timescale 1ns/1ps
module ars_drive_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bench control
	input wire logic run_en,
	input wire logic hit,
	input wire logic brk,
	input wire logic slow,
	input wire logic clr_en,
	input wire logic mack,
	// sequencer side
	input wire logic fault_ack,
	input wire logic switch_on_request,
	input wire logic restart_failed_fault,
	output logic run_command,
	output logic ramp_stop_command,
	output logic fault_active,
	output logic manual_ack,
	output logic start_done
);
	int dly;
	logic clr;
	assign clr = restart_failed_fault && clr_en && !ramp_stop_command;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{run_command, ramp_stop_command} <= 2'b00;
			{fault_active, manual_ack, start_done} <= 3'b000;
			dly <= 0;
		end else begin
			run_command <= run_en;
			ramp_stop_command <= clr;
			manual_ack <= mack || clr;
			fault_active <= hit || (brk && start_done && switch_on_request)
				|| (fault_active && !fault_ack && run_en);
			if (switch_on_request && !fault_active) begin
				dly <= dly + 1;
				start_done <= dly >= (slow ? 20 : 2);
			end else begin
				dly <= 0;
				start_done <= 1'b0;
			end
		end
	end
endmodule

// File: test/tb_top.sv
// self-checking bench of the restart sequencer
`timescale 1ns/1ps
module tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rs, r;
	logic run_en, hit, brk, slow, clr_en, mack, power_fail, son_q;
	logic run_command, ramp_stop_command, fault_active, manual_ack;
	logic start_done, fault_ack, son, restart_failed_fault;
	int n_errors = 0, num_checks = 0, cyc = 0, w;
	int n_ack = 0, n_son = 0, t_ack = 0, t_son = 0, d_son = 0, d_hi = 0;
	logic [7:0] modes [7] = '{8'h00, 8'h01, 8'h04, 8'h06, 8'h0e, 8'h10, 8'h1a};
	ars_sequencer #(.CYC_PER_MS(4)) u_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .run_command,
		.ramp_stop_command, .fault_active, .power_fail, .manual_ack,
		.start_done, .fault_ack, .switch_on_request(son), .restart_failed_fault);
	ars_drive_model u_drv (.pclk, .presetn, .run_en, .hit, .brk, .slow,
		.clr_en, .mack, .fault_ack, .switch_on_request(son),
		.restart_failed_fault, .run_command, .ramp_stop_command,
		.fault_active, .manual_ack, .start_done);
	// ************************************************************
	// clock, monitor and timeout
	// ************************************************************
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		son_q <= son;
		if (fault_ack === 1'b1) begin
			n_ack++;
			t_ack = cyc;
		end
		if (son === 1'b1 && son_q !== 1'b1) begin
			n_son++;
			d_son = cyc - t_ack;
			t_son = cyc;
		end
		if (son !== 1'b1 && son_q === 1'b1) d_hi = cyc - t_son;
		if (cyc == 40000) begin
			n_errors++;
			give_verdict();
		end
	end
	// ************************************************************
	// tasks
	// ************************************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic [31:0] m = 32'hffffffff);
		apb(1'b0, a, 32'h0);
		chk(r & m, x);
		chk(e, 1'b0);
	endtask
	task automatic fire(input int n);
		@(posedge pclk);
		hit <= 1'b1;
		@(posedge pclk);
		hit <= 1'b0;
		repeat (n) @(posedge pclk);
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	initial begin
		int k;
		{psel, penable, pwrite, run_en, hit, brk, clr_en, mack} = 8'h00;
		{power_fail, slow, paddr, pwdata, rs} = {2'b00, 8'h00, 32'h0, 32'd39};
		presetn = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h3);
		rd(8'h08, 32'd1000);
		rd(8'h10, 32'h3);
		rs = xs(rs);
		apb(1'b1, 8'h14, rs);
		chk(e, 1'b1);
		fire(30);
		chk(32'(n_ack), 32'h0);
		foreach (modes[i]) begin
			apb(1'b1, 8'h00, {24'h0, modes[i]});
			rd(8'h00, {24'h0, modes[i]});
			rd(8'h10, 32'h3);
		end
		rs = xs(rs);
		apb(1'b1, 8'h00, {24'h0, rs[7:0] | 8'h20});
		apb(1'b1, 8'h10, 32'h0);
		rd(8'h10, 32'h403);
		apb(1'b1, 8'h00, 32'h4);
		fire(30);
		chk(32'(n_ack), 32'h0);
		apb(1'b1, 8'h00, 32'h1);
		run_en <= 1'b1;
		fire(30);
		chk(32'(n_ack), 32'h1);
		chk(32'(n_son), 32'h0);
		rd(8'h10, 32'h3, 32'hff);
		apb(1'b1, 8'h00, 32'h10);
		fire(30);
		chk(32'(n_ack), 32'h1);
		mack <= 1'b1;
		@(posedge pclk);
		mack <= 1'b0;
		repeat (30) @(posedge pclk);
		chk(32'(n_ack), 32'h2);
		chk(32'(n_son), 32'h1);
		chk(d_son < 100, 1'b1);
		rd(8'h10, 32'h2, 32'hff);
		apb(1'b1, 8'h04, 32'h5);
		rd(8'h10, 32'h5, 32'hff);
		apb(1'b1, 8'h04, 32'h2);
		rs = xs(rs);
		w = 1 + int'(rs[1:0]);
		apb(1'b1, 8'h08, 32'(w));
		apb(1'b1, 8'h00, 32'h4);
		slow <= 1'b1;
		power_fail <= 1'b1;
		@(posedge pclk);
		power_fail <= 1'b0;
		for (k = 0; k < 200 && son !== 1'b1; k++) @(posedge pclk);
		@(posedge pclk);
		chk(d_son >= 4 * w, 1'b1);
		rd(8'h10, 32'h1, 32'hff);
		for (k = 0; k < 6000 && son === 1'b1; k++) @(posedge pclk);
		repeat (5) @(posedge pclk);
		chk(d_hi >= 4000, 1'b1);
		rd(8'h10, 32'h2, 32'hff);
		slow <= 1'b0;
		brk <= 1'b1;
		for (int lim = 0; lim < 3; lim += 2) begin
			apb(1'b1, 8'h00, 32'h0);
			apb(1'b1, 8'h04, 32'(lim));
			apb(1'b1, 8'h00, 32'h1a);
			n_ack = 0;
			n_son = 0;
			fire(0);
			for (k = 0; k < 3000 && restart_failed_fault !== 1'b1; k++)
				@(posedge pclk);
			chk(32'(n_son), 32'(lim + 1));
			chk(32'(n_ack), 32'(lim + 1));
			clr_en <= 1'b1;
			repeat (5) @(posedge pclk);
			clr_en <= 1'b0;
			chk(restart_failed_fault, 1'b0);
			rd(8'h10, 32'(lim), 32'hff);
		end
		give_verdict();
	end
endmodule
